// ===== rtl/dcs_cfg.svh
// Constants of the drive command and status word interpreter.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

// Word widths
`define DCS_WORD_W 16
`define DCS_DIN_W 6

// Reset value of the applied command word: coast, brake and freeze active
`define DCS_CMD_RST 16'h0000
`define DCS_STAT_RST 16'h0000

// Digital input positions inside the synchronised input vector
`define DCS_DIN_BRAKE 0
`define DCS_DIN_COAST 1
`define DCS_DIN_RST_COAST 2
`define DCS_DIN_SPEED_UP 3
`define DCS_DIN_SLOW_DOWN 4
`define DCS_DIN_REVERSE 5

// Scaling: 16384 stands for 100 percent
`define DCS_FULL_SCALE 32'h0000_4000
`define DCS_FULL_SHIFT 14
`define DCS_MAV_FRAC 32'h0001_0000
`define DCS_MAV_SHIFT 16
`define DCS_POS_MAX 16'h7FFF
`define DCS_NEG_MAX 16'h8000
`define DCS_ZERO16 16'h0000

`endif

// ===== rtl/dcs_cmd_stat.sv
// Drive command word interpreter and status word builder, with scaling
// of the bus speed reference and the actual output value.
// Assumes telegram strobes and core status inputs all arrive on clk_sys_i.
// Contract
// - While frozen only coast, DC brake or matching digital inputs stop.
// - Bit 06 low ramps to stop on selected ramp; high permits start.
// - Trip reset only on 0 to 1 change of bit 07.
// - Bit 08 high takes output frequency from jog speed setting.
// - Bit 09 selects ramp pair one or two.
// - Bit 10 low discards the whole word; high applies it.
// - Bit 11 drives relay 01 only when its function follows bit 11.
// - Bit 12 drives relay 04 only when its function follows bit 12.
// - Bits 14:13 pick set-up 1 to 4 when multi set-up is enabled.
// - Bit 15 reverses only with bus, AND or OR reverse source.
// - Status bit 00 shows control ready, zero when tripped.
// - Status bit 01 shows drive ready even while coast is active.
// - Status bit 02 low while coasting, high when start is possible.
// - Status bits 03, 04, 06 flag trip, error, locked trip.
// - Status bit 07 flags any warning; bit 05 always zero.
// - Status bit 08 shows speed equals reference.
// - Status bit 09 shows bus control possible, zero in local.
// - Status bit 10 high while output frequency within limits.
// - Status bit 11 high on start signal or nonzero output frequency.
// - Status bits 12 to 15 flag auto-stop, voltage, current, thermal.
// - Whole status word zero on link loss or internal fault.
// - Reference and actual value are signed 16 bit, 16384 is 100 percent.
// - Bits 01:00 select one of four preset references.
// - Bit 02 low DC-brakes and stops; high selects ramping.
// - Bit 03 low coasts at once; high allows start.
// - Bit 05 low freezes output; only speed-up/slow-down inputs change it. A set bit 08 still selects jog speed while frozen.
`timescale 1ns/1ps
`include "dcs_cfg.svh"
module dcs_cmd_stat #(
    parameter logic [15:0] FMAX = 16'h3A98,
    parameter logic [15:0] STEP = 16'h0010
) (
    // Clock and reset
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_b_i,
    // Telegram in and reply strobe
    input  wire logic                    rx_valid_i,
    input  wire dcs_pkg::dcs_cmd_t       rx_cmd_i,
    input  wire logic signed [15:0]      rx_bus_ref_i,
    output logic                         status_valid_o,
    output dcs_pkg::dcs_stat_t           drive_status_flags_o,
    output logic signed [15:0]           actual_output_value_o,
    // Configuration
    input  wire logic                    relay1_follow_i,
    input  wire logic                    relay4_follow_i,
    input  wire logic                    multi_setup_i,
    input  wire dcs_pkg::dcs_rev_src_t   rev_src_i,
    input  wire logic signed [15:0]      jog_speed_setting_i,
    input  wire logic [15:0]             speed_low_lim_i,
    input  wire logic [15:0]             speed_high_lim_i,
    // Digital input pins
    input  wire logic [`DCS_DIN_W-1:0]   din_i,
    // Motor core status
    input  wire logic                    ctrl_ready_i,
    input  wire logic                    drive_ready_i,
    input  wire logic                    tripped_i,
    input  wire logic                    trip_locked_i,
    input  wire logic                    error_i,
    input  wire logic                    warning_i,
    input  wire logic                    at_ref_i,
    input  wire logic                    local_stop_i,
    input  wire logic                    local_mode_i,
    input  wire logic                    start_i,
    input  wire logic                    auto_stop_i,
    input  wire logic                    volt_exc_i,
    input  wire logic                    cur_exc_i,
    input  wire logic                    therm_exc_i,
    input  wire logic                    link_lost_i,
    input  wire logic                    comm_fault_i,
    input  wire logic signed [15:0]      out_freq_i,
    // Motor core controls
    output logic                         coast_o,
    output logic                         dc_brake_o,
    output logic                         quick_stop_o,
    output logic                         run_o,
    output logic                         frozen_o,
    output logic                         trip_reset_o,
    output logic                         jog_o,
    output logic                         ramp2_o,
    output logic                         relay1_o,
    output logic                         relay4_o,
    output logic [1:0]                   setup_o,
    output logic                         reverse_o,
    output logic [1:0]                   preset_sel_o,
    output logic signed [15:0]           speed_ref_o
);

    localparam logic [31:0] MAV_GAIN = 32'((`DCS_FULL_SCALE * `DCS_MAV_FRAC) / 32'(FMAX));

    dcs_pkg::dcs_state_t state_r;
    dcs_pkg::dcs_cmd_t rx_r, cmd_r;
    dcs_pkg::dcs_stat_t st_nxt;
    logic signed [15:0] bus_ref_r, held_r, ref_scaled, mav_scaled, speed_ref_nxt;
    logic signed [32:0] ref_prod;
    logic signed [48:0] mav_prod;
    logic [15:0] freq_abs;
    logic [`DCS_DIN_W-1:0] din_s, din_q_r;
    logic last_reset_r, frozen_q_r, frozen, rev_nxt;
    logic up_edge, down_edge, din_coast, din_brake;

    // Saturate a wide signed value to a 16 bit word
    function automatic logic signed [15:0] sat16(input logic signed [48:0] v);
        logic signed [48:0] hi;
        logic signed [48:0] lo;
        hi = 49'(signed'(`DCS_POS_MAX));
        lo = 49'(signed'(`DCS_NEG_MAX));
        sat16 = (v > hi) ? signed'(`DCS_POS_MAX) : (v < lo) ? signed'(`DCS_NEG_MAX) : v[15:0];
    endfunction

    // Pin inputs through two flip-flops
    dcs_sync #(.W(`DCS_DIN_W)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .d_i(din_i),
        .q_o(din_s)
    );

    assign frozen = ~cmd_r.hold_n;
    assign din_brake = din_s[`DCS_DIN_BRAKE];
    assign din_coast = din_s[`DCS_DIN_COAST] | din_s[`DCS_DIN_RST_COAST];
    assign up_edge = din_s[`DCS_DIN_SPEED_UP] & ~din_q_r[`DCS_DIN_SPEED_UP];
    assign down_edge = din_s[`DCS_DIN_SLOW_DOWN] & ~din_q_r[`DCS_DIN_SLOW_DOWN];

    // Telegram sequencing: take, apply, reply
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= dcs_pkg::DCS_ST_IDLE;
        end else begin
            case (state_r)
                dcs_pkg::DCS_ST_IDLE: state_r <= rx_valid_i ? dcs_pkg::DCS_ST_APPLY
                                                            : dcs_pkg::DCS_ST_IDLE;
                dcs_pkg::DCS_ST_APPLY: state_r <= dcs_pkg::DCS_ST_REPLY;
                dcs_pkg::DCS_ST_REPLY: state_r <= dcs_pkg::DCS_ST_IDLE;
                default: state_r <= dcs_pkg::DCS_ST_IDLE;
            endcase
        end
    end

    // Received word and bus reference capture
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_r <= `DCS_CMD_RST;
            bus_ref_r <= `DCS_ZERO16;
        end else if (rx_valid_i && state_r == dcs_pkg::DCS_ST_IDLE) begin
            rx_r <= rx_cmd_i;
            bus_ref_r <= rx_bus_ref_i;
        end
    end

    // Applied command word, only from words marked valid
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_r <= `DCS_CMD_RST;
            last_reset_r <= 1'b0;
        end else if (state_r == dcs_pkg::DCS_ST_APPLY && rx_r.data_valid) begin
            cmd_r <= rx_r;
            last_reset_r <= rx_r.reset;
        end
    end

    // Trip reset pulse on leading edge only
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trip_reset_o <= 1'b0;
        end else begin
            trip_reset_o <= state_r == dcs_pkg::DCS_ST_APPLY && rx_r.data_valid
                            && rx_r.reset && !last_reset_r;
        end
    end

    // Reverse source selection
    always_comb begin
        case (rev_src_i)
            dcs_pkg::DCS_REV_BUS: rev_nxt = cmd_r.reverse;
            dcs_pkg::DCS_REV_AND: rev_nxt = cmd_r.reverse & din_s[`DCS_DIN_REVERSE];
            dcs_pkg::DCS_REV_OR: rev_nxt = cmd_r.reverse | din_s[`DCS_DIN_REVERSE];
            default: rev_nxt = din_s[`DCS_DIN_REVERSE];
        endcase
    end

    // Stop, brake, coast and run controls
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            coast_o <= 1'b1;
            dc_brake_o <= 1'b1;
            quick_stop_o <= 1'b0;
            run_o <= 1'b0;
            frozen_o <= 1'b0;
        end else begin
            coast_o <= ~cmd_r.coast_n | din_coast;
            dc_brake_o <= ~cmd_r.brake_n | din_brake;
            quick_stop_o <= ~cmd_r.quick_n & ~frozen;
            run_o <= cmd_r.run | frozen;
            frozen_o <= frozen;
        end
    end

    // Ramp, jog, relays, set-up, reverse and preset selection
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            jog_o <= 1'b0;
            ramp2_o <= 1'b0;
            relay1_o <= 1'b0;
            relay4_o <= 1'b0;
            setup_o <= 2'h0;
            reverse_o <= 1'b0;
            preset_sel_o <= 2'h0;
        end else begin
            jog_o <= cmd_r.jog;
            ramp2_o <= cmd_r.ramp2;
            relay1_o <= cmd_r.relay1 & relay1_follow_i;
            relay4_o <= cmd_r.relay4 & relay4_follow_i;
            setup_o <= multi_setup_i ? cmd_r.setup : setup_o;
            reverse_o <= rev_nxt;
            preset_sel_o <= cmd_r.ref_sel;
        end
    end

    // Frozen frequency, moved only by speed-up and slow-down inputs
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            held_r <= `DCS_ZERO16;
            frozen_q_r <= 1'b0;
            din_q_r <= '0;
        end else begin
            frozen_q_r <= frozen;
            din_q_r <= din_s;
            if (frozen && !frozen_q_r) begin
                held_r <= out_freq_i;
            end else if (frozen && up_edge) begin
                held_r <= 16'(held_r + signed'(STEP));
            end else if (frozen && down_edge) begin
                held_r <= 16'(held_r - signed'(STEP));
            end
        end
    end

    // Scaling between relative words and core units
    always_comb begin
        ref_prod = 33'(bus_ref_r) * 33'(signed'({1'b0, FMAX}));
        mav_prod = 49'(out_freq_i) * 49'(signed'({1'b0, MAV_GAIN}));
        ref_scaled = sat16(49'(ref_prod >>> `DCS_FULL_SHIFT));
        mav_scaled = sat16(mav_prod >>> `DCS_MAV_SHIFT);
        speed_ref_nxt = cmd_r.jog ? jog_speed_setting_i : frozen ? held_r : ref_scaled;
    end

    // Status word assembly
    always_comb begin
        freq_abs = out_freq_i[15] ? 16'(-out_freq_i) : out_freq_i;
        st_nxt = `DCS_STAT_RST;
        st_nxt.ctrl_ready = ctrl_ready_i & ~tripped_i;
        st_nxt.drive_ready = drive_ready_i;
        st_nxt.enable = ~coast_o;
        st_nxt.trip = tripped_i;
        st_nxt.err_notrip = error_i;
        st_nxt.spare = 1'b0;
        st_nxt.triplock = trip_locked_i;
        st_nxt.warning = warning_i;
        st_nxt.at_ref = at_ref_i;
        st_nxt.bus_ctrl = ~local_stop_i & ~local_mode_i;
        st_nxt.freq_ok = freq_abs > speed_low_lim_i && freq_abs < speed_high_lim_i;
        st_nxt.in_oper = start_i | (out_freq_i != `DCS_ZERO16);
        st_nxt.auto_stop = auto_stop_i;
        st_nxt.volt_exc = volt_exc_i;
        st_nxt.torque_exc = cur_exc_i;
        st_nxt.timer_exc = therm_exc_i;
        if (link_lost_i || comm_fault_i) begin
            st_nxt = `DCS_STAT_RST;
        end
    end

    // Status, actual value, speed reference and reply strobe
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drive_status_flags_o <= `DCS_STAT_RST;
            actual_output_value_o <= `DCS_ZERO16;
            speed_ref_o <= `DCS_ZERO16;
            status_valid_o <= 1'b0;
        end else begin
            drive_status_flags_o <= st_nxt;
            actual_output_value_o <= mav_scaled;
            speed_ref_o <= speed_ref_nxt;
            status_valid_o <= state_r == dcs_pkg::DCS_ST_REPLY;
        end
    end

    // Checks
    sequence telegram_s;
        rx_valid_i && state_r == dcs_pkg::DCS_ST_IDLE ##1 state_r == dcs_pkg::DCS_ST_APPLY;
    endsequence
    sequence applied_reset_s;
        state_r == dcs_pkg::DCS_ST_APPLY && rx_r.data_valid && rx_r.reset && !last_reset_r;
    endsequence

    reply_once_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        telegram_s |=> ##1 status_valid_o ##1 !status_valid_o)
        else $error("reply strobe not one cycle after apply");
    ignore_invalid_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        state_r == dcs_pkg::DCS_ST_APPLY && !rx_r.data_valid |=> $stable(cmd_r))
        else $error("invalid command word was applied");
    reset_edge_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        trip_reset_o |-> $past(state_r == dcs_pkg::DCS_ST_APPLY && !last_reset_r))
        else $error("trip reset without leading edge");
    reset_fires_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        applied_reset_s |=> trip_reset_o ##1 !trip_reset_o)
        else $error("trip reset pulse missing or too long");
    freeze_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !cmd_r.hold_n |=> run_o && !quick_stop_o)
        else $error("ramp stop acted while frozen");
    coast_cmd_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !cmd_r.coast_n |=> coast_o ##1 !drive_status_flags_o.enable)
        else $error("coast command not reflected");
    jog_speed_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        cmd_r.jog |=> jog_o && speed_ref_o == $past(jog_speed_setting_i))
        else $error("jog speed not taken");
    relay_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        relay1_o |-> $past(cmd_r.relay1 && relay1_follow_i))
        else $error("relay 01 energised without selection");
    status_loss_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        link_lost_i || comm_fault_i |=> drive_status_flags_o == `DCS_STAT_RST)
        else $error("status word not cleared on link loss");
    spare_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !drive_status_flags_o.spare)
        else $error("unused status bit set");
    trip_ready_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        $past(tripped_i) |-> !drive_status_flags_o.ctrl_ready)
        else $error("control ready shown while tripped");

endmodule

// ===== rtl/dcs_pkg.sv
// Types of the drive command and status word interpreter.
// Assumes nothing of its surroundings; field order follows bit order.
package dcs_pkg;

    // Command word, bit 15 first
    typedef struct packed {
        logic       reverse;
        logic [1:0] setup;
        logic       relay4;
        logic       relay1;
        logic       data_valid;
        logic       ramp2;
        logic       jog;
        logic       reset;
        logic       run;
        logic       hold_n;
        logic       quick_n;
        logic       coast_n;
        logic       brake_n;
        logic [1:0] ref_sel;
    } dcs_cmd_t;

    // Status word, bit 15 first
    typedef struct packed {
        logic timer_exc;
        logic torque_exc;
        logic volt_exc;
        logic auto_stop;
        logic in_oper;
        logic freq_ok;
        logic bus_ctrl;
        logic at_ref;
        logic warning;
        logic triplock;
        logic spare;
        logic err_notrip;
        logic trip;
        logic enable;
        logic drive_ready;
        logic ctrl_ready;
    } dcs_stat_t;

    // Source of the reverse command
    typedef enum logic [1:0] {
        DCS_REV_DIN = 2'h0,
        DCS_REV_BUS = 2'h1,
        DCS_REV_AND = 2'h2,
        DCS_REV_OR  = 2'h3
    } dcs_rev_src_t;

    // Telegram handling, Gray coded from idle to reply; reply back to idle flips both bits
    typedef enum logic [1:0] {
        DCS_ST_IDLE  = 2'h0,
        DCS_ST_APPLY = 2'h1,
        DCS_ST_REPLY = 2'h3
    } dcs_state_t;

endpackage

// ===== rtl/dcs_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin inputs.
// Assumes each bit is an independent level; no bus coherence is kept.
`timescale 1ns/1ps
module dcs_sync #(
    parameter int W = 6
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_b_i,
    // Pins and synchronised levels
    input  wire logic [W-1:0] d_i,
    output logic [W-1:0]      q_o
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule

// ===== testbench/dcs_cmd_stat_tb.sv
// Testbench of the command and status word block, driven by the master model.
// Assumes the block runs with a reduced maximum frequency FMAX of 16'h2000.
`timescale 1ns/1ps
module dcs_cmd_stat_tb;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, rx_valid_i, status_valid_o;
    dcs_pkg::dcs_cmd_t rx_cmd_i;
    dcs_pkg::dcs_stat_t drive_status_flags_o;
    logic signed [15:0] rx_bus_ref_i, actual_output_value_o, speed_ref_o;
    logic relay1_follow_i = 1'b1, relay4_follow_i = 1'b1, multi_setup_i = 1'b1;
    dcs_pkg::dcs_rev_src_t rev_src_i = dcs_pkg::DCS_REV_DIN;
    logic signed [15:0] jog_speed_setting_i = 16'h0123, out_freq_i = 16'h0000;
    logic [15:0] speed_low_lim_i = 16'h000A, speed_high_lim_i = 16'h03E8;
    logic [5:0] din_i = 6'h00;
    logic ctrl_ready_i = 1'b0, drive_ready_i = 1'b0, tripped_i = 1'b0, trip_locked_i = 1'b0;
    logic error_i = 1'b0, warning_i = 1'b0, at_ref_i = 1'b0, local_stop_i = 1'b0;
    logic local_mode_i = 1'b0, start_i = 1'b0, auto_stop_i = 1'b0, volt_exc_i = 1'b0;
    logic cur_exc_i = 1'b0, therm_exc_i = 1'b0, link_lost_i = 1'b0, comm_fault_i = 1'b0;
    logic coast_o, dc_brake_o, quick_stop_o, run_o, frozen_o, trip_reset_o, jog_o, ramp2_o;
    logic relay1_o, relay4_o, reverse_o;
    logic [1:0] setup_o, preset_sel_o, k;
    int n_mismatch = 0, n_tests = 0, n_trst = 0;

    dcs_cmd_stat #(.FMAX(16'h2000), .STEP(16'h0010)) dut (
        .clk_sys_i, .rst_b_i, .rx_valid_i, .rx_cmd_i, .rx_bus_ref_i, .status_valid_o,
        .drive_status_flags_o, .actual_output_value_o, .relay1_follow_i, .relay4_follow_i,
        .multi_setup_i, .rev_src_i, .jog_speed_setting_i, .speed_low_lim_i, .speed_high_lim_i,
        .din_i, .ctrl_ready_i, .drive_ready_i, .tripped_i, .trip_locked_i, .error_i,
        .warning_i, .at_ref_i, .local_stop_i, .local_mode_i, .start_i, .auto_stop_i,
        .volt_exc_i, .cur_exc_i, .therm_exc_i, .link_lost_i, .comm_fault_i, .out_freq_i,
        .coast_o, .dc_brake_o, .quick_stop_o, .run_o, .frozen_o, .trip_reset_o, .jog_o,
        .ramp2_o, .relay1_o, .relay4_o, .setup_o, .reverse_o, .preset_sel_o, .speed_ref_o);

    dcs_master mst (.clk_sys_i(clk_sys_i), .stat_vld_i(status_valid_o),
        .stat_i(drive_status_flags_o), .tel_vld_o(rx_valid_i), .tel_cmd_o(rx_cmd_i),
        .tel_ref_o(rx_bus_ref_i));

    // 20 MHz clock
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    // Count trip reset pulses
    always @(posedge clk_sys_i) begin
        if (trip_reset_o === 1'b1) n_trst++;
    end

    task automatic summarize();
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One telegram; a missing reply ends the run
    task automatic tx(input logic [15:0] c, input logic signed [15:0] r);
        bit ok;
        mst.send(c, r, ok);
        if (!ok) begin
            n_mismatch++;
            $display("Error reply strobe expected 1 seen 0");
            summarize();
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_sys_i);
    endtask

    initial begin
        repeat (12) @(posedge clk_sys_i);
        chk("coast at reset", 16'h1, coast_o);
        chk("brake at reset", 16'h1, dc_brake_o);
        rst_b_i <= 1'b1;
        tx(16'h047C, 16'sh4000);
        chk("coast", 16'h0, coast_o);
        chk("brake", 16'h0, dc_brake_o);
        chk("run", 16'h1, run_o);
        chk("speed ref", 16'h2000, speed_ref_o);
        tx(16'h80F0, 16'sh4000);
        chk("coast kept", 16'h0, coast_o);
        chk("run kept", 16'h1, run_o);
        chk("no reset", 16'h0, n_trst[15:0]);
        $display("Test basic done");
        @(posedge clk_sys_i);
        {ctrl_ready_i, drive_ready_i, error_i, warning_i, at_ref_i} <= 5'h1F;
        {auto_stop_i, cur_exc_i} <= 2'h3;
        out_freq_i <= 16'sh0064;
        settle();
        chk("status", 16'h5F97, drive_status_flags_o);
        tx(16'h047C, 16'sh4000);
        chk("status", 16'h5F97, mst.last_stat);
        {tripped_i, trip_locked_i, error_i} <= 3'h6;
        settle();
        chk("status trip", 16'h5FCE, drive_status_flags_o);
        local_mode_i <= 1'b1;
        settle();
        chk("status local", 16'h5DCE, drive_status_flags_o);
        link_lost_i <= 1'b1;
        settle();
        chk("status lost", 16'h0000, drive_status_flags_o);
        {link_lost_i, comm_fault_i} <= 2'h1;
        settle();
        chk("status fault", 16'h0000, drive_status_flags_o);
        {comm_fault_i, local_mode_i, tripped_i, trip_locked_i} <= 4'h0;
        $display("Test status done");
        tx(16'h043C, 16'sh4000);
        chk("ramp stop", 16'h0, run_o);
        tx(16'h04FC, 16'sh4000);
        chk("reset pulse", 16'h1, n_trst[15:0]);
        tx(16'h04FC, 16'sh4000);
        chk("reset level", 16'h1, n_trst[15:0]);
        tx(16'h047C, 16'sh4000);
        tx(16'h04FC, 16'sh4000);
        chk("reset again", 16'h2, n_trst[15:0]);
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            tx(16'h047C | {1'b0, k, k[1], k[0], 1'b0, k[0], 9'h000} | 16'(k), 16'sh4000);
            chk("setup", 16'(k), setup_o);
            chk("preset", 16'(k), preset_sel_o);
            chk("ramp2", 16'(k[0]), ramp2_o);
            chk("relay1", 16'(k[0]), relay1_o);
            chk("relay4", 16'(k[1]), relay4_o);
        end
        @(posedge clk_sys_i);
        {multi_setup_i, relay1_follow_i, relay4_follow_i} <= 3'h0;
        tx(16'h1C7C, 16'sh4000);
        chk("setup held", 16'h3, setup_o);
        chk("relay1 off", 16'h0, relay1_o);
        chk("relay4 off", 16'h0, relay4_o);
        tx(16'h057C, 16'sh4000);
        chk("jog", 16'h1, jog_o);
        chk("jog speed", 16'h0123, speed_ref_o);
        $display("Test fields done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_i);
            rev_src_i <= dcs_pkg::dcs_rev_src_t'(i);
            tx(16'h847C, -16'sh4000);
            chk("reverse", 16'(i == 1 || i == 3), reverse_o);
        end
        chk("speed neg", 16'hE000, speed_ref_o);
        tx(16'h045C, 16'sh4000);
        repeat (2) @(posedge clk_sys_i);
        chk("frozen", 16'h1, frozen_o);
        chk("frozen run", 16'h1, run_o);
        chk("frozen ref", 16'h0064, speed_ref_o);
        tx(16'h044C, 16'sh4000);
        chk("frozen quick", 16'h0, quick_stop_o);
        chk("frozen run kept", 16'h1, run_o);
        din_i <= 6'h08;
        settle();
        settle();
        chk("speed up", 16'h0074, speed_ref_o);
        din_i <= 6'h03;
        settle();
        settle();
        chk("din brake", 16'h1, dc_brake_o);
        chk("din coast", 16'h1, coast_o);
        din_i <= 6'h00;
        tx(16'h0454, 16'sh4000);
        chk("frozen coast", 16'h1, coast_o);
        $display("Test freeze done");
        @(posedge clk_sys_i);
        out_freq_i <= -16'sh2000;
        settle();
        chk("actual value", 16'hC000, actual_output_value_o);
        $display("Test scaling done");
        summarize();
    end
endmodule

// ===== testbench/dcs_master.sv
// Bus master model: one command word and one reference per telegram.
// Assumes the block's clock and its one-cycle reply strobe.
`timescale 1ns/1ps
module dcs_master (
    // Clock and reply
    input wire logic clk_sys_i,
    input wire logic stat_vld_i,
    input wire dcs_pkg::dcs_stat_t stat_i,
    // Telegram out
    output logic tel_vld_o,
    output dcs_pkg::dcs_cmd_t tel_cmd_o,
    output logic signed [15:0] tel_ref_o
);
    dcs_pkg::dcs_stat_t last_stat;
    initial begin
        tel_vld_o = 1'b0;
        tel_cmd_o = 16'h0000;
        tel_ref_o = 16'h0000;
    end
    // Word held for the taking edge only, then lines flip to the inverted word
    task automatic send(input logic [15:0] cmd, input logic signed [15:0] ref_v, output bit ok);
        ok = 1'b0;
        @(posedge clk_sys_i);
        tel_vld_o <= 1'b1;
        tel_cmd_o <= cmd;
        tel_ref_o <= ref_v;
        @(posedge clk_sys_i);
        tel_vld_o <= 1'b0;
        tel_cmd_o <= ~cmd;
        tel_ref_o <= ~ref_v;
        for (int n = 0; n < 8 && !ok; n++) begin
            @(posedge clk_sys_i);
            if (stat_vld_i === 1'b1) begin
                last_stat = stat_i;
                ok = 1'b1;
            end
        end
    endtask
endmodule
